// ==== ioexp_regs.sv ====
// two-wire slave, register file and interrupt logic of the 16-bit io expander
//
// How it works
// (RULE_01) answer address 0100 plus three select pins
// (RULE_02) address bit zero: one reads, zero writes
// (RULE_03) first write byte after address is command
// (RULE_04) low three command bits pick one register
// (RULE_05) reads restart at stored command register
// (RULE_06) level registers show pins, ignore writes
// (RULE_07) drive registers reset ones, read stored value
// (RULE_08) invert registers reset zero, flip sensed level
// (RULE_09) direction reset ones; one input, zero output
// (RULE_10) data byte stored into selected register
// (RULE_11) each byte moves to other pair register
// (RULE_12) unlimited write bytes alternate within pair
// (RULE_13) master reads via command, restart, read address
// (RULE_14) restart copies current pointer into command
// (RULE_15) read data captured at acknowledge rising edge
// (RULE_16) master nacks last read byte
// (RULE_17) stop anytime; acknowledged data stays valid
// (RULE_18) input pin edges raise interrupt, outputs never
// (RULE_19) level read clears only that port's interrupt
// (RULE_20) general call address is never acknowledged
// (RULE_21) bus lines synchronised and filtered before use
`timescale 1ns/1ps

module ioexp_regs #(
   parameter int FILT_LEN = ioexp_pkg::FILT_CYCLES
) (
   input  wire logic       clock_i,            // 50 MHz system clock
   input  wire logic       resetn_i,           // synchronous reset, active low
   input  wire logic       scl_i,              // bus clock from master
   input  wire logic       sda_i,              // bus data line level
   output logic            sda_o,              // bus data drive value, always low
   output logic            sda_oe_n_o,         // bus data pull-down enable, active low
   input  wire logic       addr_select_hi_i,   // address select pin, bit 2
   input  wire logic       addr_select_mid_i,  // address select pin, bit 1
   input  wire logic       addr_select_lo_i,   // address select pin, bit 0
   input  wire logic [7:0] first_port_pins_i,  // first port pin levels
   output logic      [7:0] first_port_pins_o,  // first port drive values
   output logic      [7:0] first_port_oe_n_o,  // first port enables, active low
   input  wire logic [7:0] second_port_pins_i, // second port pin levels
   output logic      [7:0] second_port_pins_o, // second port drive values
   output logic      [7:0] second_port_oe_n_o, // second port enables, active low
   output logic            irq_o,              // interrupt drive value, always low
   output logic            irq_oe_n_o          // interrupt pull-down enable, active low
);
   import ioexp_pkg::*;
   if (FILT_LEN < 1 || FILT_LEN > 4) begin : g_bad_filt
      $error("FILT_LEN must lie between 1 and 4");
   end
   function automatic logic [7:0] reg_read(input logic [2:0]             a,
                                           input logic [1:0][7:0]        lvl,
                                           input ioexp_port_t [1:0]      pr);
      logic [7:0] v;
      v = 8'h00;
      unique case (a[2:1])
         GRP_LVL:   v = lvl[a[0]];
         GRP_DRIVE: v = pr[a[0]].drive;
         GRP_INV:   v = pr[a[0]].invert;
         GRP_DIR:   v = pr[a[0]].dir;
      endcase
      return v;
   endfunction : reg_read
   ////////////////////////////////////////////////////////////////////////////////
   // synchronisers and glitch filter
   ioexp_bus_t           bus_s1_q, bus_s2_q;
   logic [1:0][7:0]      pin_s1_q, pin_s2_q;
   logic [2:0]           addr_s1_q, addr_s2_q;
   logic [1:0]           line_s, line_f_q;
   logic [1:0][1:0]      flt_cnt_q;
   logic                 scl_p_q, sda_p_q;
   logic                 low_q;
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         bus_s1_q  <= '{scl: 1'b1, sda: 1'b1};
         bus_s2_q  <= '{scl: 1'b1, sda: 1'b1};
         pin_s1_q  <= '0;
         pin_s2_q  <= '0;
         addr_s1_q <= 3'h0;
         addr_s2_q <= 3'h0;
         low_q     <= 1'b0;
      end else begin
         bus_s1_q  <= '{scl: scl_i, sda: sda_i};                            // RULE_21
         bus_s2_q  <= bus_s1_q;
         pin_s1_q  <= {second_port_pins_i, first_port_pins_i};
         pin_s2_q  <= pin_s1_q;
         addr_s1_q <= {addr_select_hi_i, addr_select_mid_i, addr_select_lo_i};
         addr_s2_q <= addr_s1_q;
         low_q     <= 1'b0;
      end
   end

   assign line_s = {bus_s2_q.scl, bus_s2_q.sda};
   // a level is taken only after FILT_LEN agreeing samples, so spikes under
   // that width never reach the edge detectors
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         line_f_q  <= 2'b11;
         flt_cnt_q <= '0;
         scl_p_q   <= 1'b1;
         sda_p_q   <= 1'b1;
      end else begin
         scl_p_q <= line_f_q[1];
         sda_p_q <= line_f_q[0];
         for (int g = 0; g < 2; g++) begin
            if (line_s[g] == line_f_q[g]) begin
               flt_cnt_q[g] <= 2'h0;
            end else if (flt_cnt_q[g] == 2'(FILT_LEN - 1)) begin
               line_f_q[g]  <= line_s[g];                                   // RULE_21
               flt_cnt_q[g] <= 2'h0;
            end else begin
               flt_cnt_q[g] <= flt_cnt_q[g] + 2'h1;
            end
         end
      end
   end
   logic scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det;
   assign scl_f     = line_f_q[1];
   assign sda_f     = line_f_q[0];
   assign scl_rise  = scl_f & ~scl_p_q;
   assign scl_fall  = ~scl_f & scl_p_q;
   assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
   assign stop_det  = scl_f & scl_p_q & ~sda_p_q & sda_f;
   ////////////////////////////////////////////////////////////////////////////////
   // byte engine
   ioexp_state_t         state_q;
   logic [3:0]           bit_cnt_q;
   logic [7:0]           shift_q;
   logic                 got_addr_q, got_cmd_q, rw_q, mack_q, sda_oe_n_q;
   logic [2:0]           cmd_q, ptr_q;
   ioexp_port_t [1:0]    port_q;
   logic [1:0][7:0]      lvl;
   logic [7:0]           cur_rd, nxt_rd;
   logic                 byte_done, addr_match, cmd_en, wr_en, rack_rise;
   assign lvl[0]     = pin_s2_q[0] ^ port_q[0].invert;                      // RULE_08
   assign lvl[1]     = pin_s2_q[1] ^ port_q[1].invert;
   assign cur_rd     = reg_read(ptr_q, lvl, port_q);                        // RULE_04
   assign nxt_rd     = reg_read(ptr_q ^ 3'h1, lvl, port_q);
   assign byte_done  = (state_q == ST_RX) & scl_fall & (bit_cnt_q == BITS_PER_BYTE);
   assign addr_match = shift_q[7:1] == {DEV_ADDR_FIXED, addr_s2_q};         // RULE_01 RULE_20
   assign cmd_en     = byte_done & got_addr_q & ~got_cmd_q & ~rw_q;         // RULE_03
   assign wr_en      = byte_done & got_addr_q & got_cmd_q;                  // RULE_10 RULE_12
   assign rack_rise  = (state_q == ST_RACK) & scl_rise;
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         state_q    <= ST_IDLE;
         bit_cnt_q  <= 4'h0;
         shift_q    <= 8'h00;
         got_addr_q <= 1'b0;
         got_cmd_q  <= 1'b0;
         rw_q       <= 1'b0;
         mack_q     <= 1'b0;
         sda_oe_n_q <= 1'b1;
      end else if (stop_det) begin
         state_q    <= ST_IDLE;                                             // RULE_17
         got_addr_q <= 1'b0;
         sda_oe_n_q <= 1'b1;
      end else if (start_det) begin
         state_q    <= ST_RX;
         bit_cnt_q  <= 4'h0;
         got_addr_q <= 1'b0;
         got_cmd_q  <= 1'b0;
         rw_q       <= 1'b0;
         sda_oe_n_q <= 1'b1;
      end else begin
         unique case (state_q)
            ST_IDLE: ;
            ST_RX: begin
               if (scl_rise && bit_cnt_q != BITS_PER_BYTE) begin
                  shift_q   <= {shift_q[6:0], sda_f};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_done) begin
                  if (!got_addr_q && !addr_match) begin
                     state_q <= ST_IDLE;                                    // RULE_20
                  end else begin
                     state_q    <= ST_ACK;
                     sda_oe_n_q <= 1'b0;
                     if (!got_addr_q) begin
                        got_addr_q <= 1'b1;
                        rw_q       <= shift_q[0];                           // RULE_02
                     end else begin
                        got_cmd_q <= 1'b1;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_rise && rw_q) begin
                  shift_q   <= cur_rd;                                      // RULE_15
                  bit_cnt_q <= 4'h0;
               end else if (scl_fall && rw_q) begin
                  state_q    <= ST_TX;
                  sda_oe_n_q <= shift_q[7];
               end else if (scl_fall) begin
                  state_q    <= ST_RX;
                  bit_cnt_q  <= 4'h0;
                  sda_oe_n_q <= 1'b1;
               end
            end
            ST_TX: begin
               if (scl_fall && bit_cnt_q == LAST_TX_BIT) begin
                  state_q    <= ST_RACK;
                  sda_oe_n_q <= 1'b1;
               end else if (scl_fall) begin
                  sda_oe_n_q <= shift_q[6];
                  shift_q    <= {shift_q[6:0], 1'b0};
                  bit_cnt_q  <= bit_cnt_q + 4'h1;
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  mack_q <= ~sda_f;
                  if (!sda_f) begin
                     shift_q   <= nxt_rd;                                   // RULE_15
                     bit_cnt_q <= 4'h0;
                  end
               end else if (scl_fall && mack_q) begin
                  state_q    <= ST_TX;
                  sda_oe_n_q <= shift_q[7];
               end else if (scl_fall) begin
                  state_q <= ST_IDLE;                                       // RULE_16
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
   // a restart keeps the register in use; a fresh start rewinds to the command
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cmd_q <= CMD_RST;
         ptr_q <= CMD_RST;
      end else if (start_det && got_addr_q) begin
         cmd_q <= ptr_q;                                                    // RULE_14
      end else if (start_det) begin
         ptr_q <= cmd_q;                                                    // RULE_05
      end else if (cmd_en) begin
         cmd_q <= shift_q[2:0];                                             // RULE_03
         ptr_q <= shift_q[2:0];
      end else if (wr_en || rack_rise) begin
         ptr_q <= ptr_q ^ 3'h1;                                             // RULE_11
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // register file and pin drive
   always_ff @(posedge clock_i) begin
      for (int p = 0; p < 2; p++) begin
         if (!resetn_i) begin
            port_q[p] <= PORT_RST;                                          // RULE_07 RULE_08 RULE_09
         end else if (wr_en && ptr_q[0] == p[0]) begin
            unique case (ptr_q[2:1])
               GRP_LVL:   port_q[p]        <= port_q[p];                    // RULE_06
               GRP_DRIVE: port_q[p].drive  <= shift_q;                      // RULE_10
               GRP_INV:   port_q[p].invert <= shift_q;
               GRP_DIR:   port_q[p].dir    <= shift_q;
            endcase
         end
      end
   end
   // drive and direction come straight from their flip-flops
   assign first_port_pins_o  = port_q[0].drive;                             // RULE_07
   assign second_port_pins_o = port_q[1].drive;
   assign first_port_oe_n_o  = port_q[0].dir;                               // RULE_09
   assign second_port_oe_n_o = port_q[1].dir;
   assign sda_o              = low_q;
   assign sda_oe_n_o         = sda_oe_n_q;
   assign irq_o              = low_q;
   ////////////////////////////////////////////////////////////////////////////////
   // interrupt: input-mode pins compared with the levels last read
   logic [1:0][7:0] snap_q;
   logic            snap_ok_q, irq_oe_n_q;
   logic [1:0]      pend;
   assign pend[0] = snap_ok_q & |((pin_s2_q[0] ^ snap_q[0]) & port_q[0].dir); // RULE_18
   assign pend[1] = snap_ok_q & |((pin_s2_q[1] ^ snap_q[1]) & port_q[1].dir);
   // a pin that returns to its snapshot level withdraws its request; turning an
   // output into an input may raise a request if the level differs
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         snap_q     <= '0;
         snap_ok_q  <= 1'b0;
         irq_oe_n_q <= 1'b1;
      end else begin
         irq_oe_n_q <= ~|pend;
         if (!snap_ok_q) begin
            snap_q    <= pin_s2_q;
            snap_ok_q <= 1'b1;
         end else if (rack_rise && ptr_q[2:1] == GRP_LVL) begin
            snap_q[ptr_q[0]] <= pin_s2_q[ptr_q[0]];                         // RULE_19
         end
      end
   end
   assign irq_oe_n_o = irq_oe_n_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   chk_reset_defaults: assert property ( // RULE_09
      $rose(resetn_i) |-> port_q[0] == PORT_RST && port_q[1] == PORT_RST && irq_oe_n_o)
      else $error("registers not at reset values");
   chk_addr_ack: assert property ( // RULE_01
      byte_done && !got_addr_q && addr_match |=> !sda_oe_n_o && got_addr_q)
      else $error("own address not acknowledged");
   chk_no_general_call: assert property ( // RULE_20
      byte_done && !got_addr_q && shift_q[7:1] == 7'h00 |=> state_q == ST_IDLE && sda_oe_n_o)
      else $error("general call acknowledged");
   chk_dir_bit: assert property ( // RULE_02
      byte_done && !got_addr_q && addr_match |=> rw_q == $past(shift_q[0]))
      else $error("direction bit not taken");
   chk_cmd_store: assert property ( // RULE_03
      cmd_en |=> cmd_q == $past(shift_q[2:0]) && ptr_q == cmd_q)
      else $error("command byte not stored");
   chk_level_ro: assert property ( // RULE_06
      wr_en && ptr_q[2:1] == GRP_LVL |=> port_q == $past(port_q))
      else $error("level register changed by write");
   chk_pair_toggle: assert property ( // RULE_11
      wr_en || rack_rise |=> ptr_q == ($past(ptr_q) ^ 3'h1))
      else $error("pointer did not move within pair");
   chk_restart_ptr: assert property ( // RULE_14
      start_det && got_addr_q && !stop_det |=> cmd_q == $past(ptr_q))
      else $error("restart did not update command");
   chk_fresh_start: assert property ( // RULE_05
      start_det && !got_addr_q |=> ptr_q == $past(cmd_q))
      else $error("start did not rewind pointer");
   chk_dir_write: assert property ( // RULE_10
      wr_en && ptr_q == REG_DIR0 |=> first_port_oe_n_o == $past(shift_q))
      else $error("direction write not applied");
   chk_read_capture: assert property ( // RULE_15
      rack_rise && !sda_f |=> shift_q == $past(nxt_rd) && bit_cnt_q == 4'h0)
      else $error("next read byte not captured");
   chk_irq_release: assert property ( // RULE_18
      !(|pend) |=> irq_oe_n_o)
      else $error("interrupt asserted without pending change");
   chk_filter_hold: assert property ( // RULE_21
      $changed(line_f_q[1]) |-> $past(line_s[1]) == line_f_q[1])
      else $error("bus clock filter took an unsettled level");

endmodule : ioexp_regs

// ==== ioexp_pkg.sv ====
// constants, carriers and states shared by the 16-bit io expander register block
package ioexp_pkg;

   // fixed upper four bits of the seven-bit slave address
   localparam logic [3:0] DEV_ADDR_FIXED = 4'h4;

   // register indices carried by the command byte
   localparam logic [2:0] REG_LVL0   = 3'h0;
   localparam logic [2:0] REG_LVL1   = 3'h1;
   localparam logic [2:0] REG_DRIVE0 = 3'h2;
   localparam logic [2:0] REG_DRIVE1 = 3'h3;
   localparam logic [2:0] REG_INV0   = 3'h4;
   localparam logic [2:0] REG_INV1   = 3'h5;
   localparam logic [2:0] REG_DIR0   = 3'h6;
   localparam logic [2:0] REG_DIR1   = 3'h7;

   // register pair groups, command bits 2..1
   localparam logic [1:0] GRP_LVL   = 2'h0;
   localparam logic [1:0] GRP_DRIVE = 2'h1;
   localparam logic [1:0] GRP_INV   = 2'h2;
   localparam logic [1:0] GRP_DIR   = 2'h3;

   // values after reset
   localparam logic [7:0] DRIVE_RST = 8'hFF;
   localparam logic [7:0] INV_RST   = 8'h00;
   localparam logic [7:0] DIR_RST   = 8'hFF;
   localparam logic [2:0] CMD_RST   = 3'h0;

   // bus line filter: cycles a new level must persist before it is taken
   localparam int         FILT_CYCLES   = 3;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;

   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] invert;
      logic [7:0] dir;
   } ioexp_port_t;

   localparam ioexp_port_t PORT_RST = '{drive: DRIVE_RST, invert: INV_RST, dir: DIR_RST};

   typedef struct packed {
      logic scl;
      logic sda;
   } ioexp_bus_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RX   = 5'b00010,
      ST_ACK  = 5'b00100,
      ST_TX   = 5'b01000,
      ST_RACK = 5'b10000
   } ioexp_state_t;

endpackage : ioexp_pkg

// ==== ioexp_master_model.sv ====
// bus master model that drives the two-wire port of the io expander
`timescale 1ns/1ps

module ioexp_master_model (
   input  wire logic clock_i,    // system clock, paces the bus
   input  wire logic sda_o,      // slave data drive value
   input  wire logic sda_oe_n_o, // slave pull-down enable, active low
   output logic      scl_o,      // bus clock, 160 ns period inside frames
   output logic      sda_line_o  // resolved data line with pull-up
);
   logic sda_m;

   initial begin
      scl_o = 1'b1;
      sda_m = 1'b1;
   end

   // pull-up wins unless one party pulls the line low
   assign sda_line_o = sda_m & (sda_oe_n_o | sda_o);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wait_n(input int n);
      repeat (n) @(posedge clock_i);
   endtask : wait_n

   // data moves one cycle after scl falls, so it never looks like a start or stop;
   // clock low five cycles so the slave's reply has settled before scl rises
   task automatic bit_xfer(input logic b, output logic r);
      @(posedge clock_i);
      sda_m <= b;
      wait_n(4);
      scl_o <= 1'b1;
      wait_n(3);
      r = sda_line_o;
      scl_o <= 1'b0;
   endtask : bit_xfer

   // also serves as repeated start when no stop came before
   task automatic start_cond();
      @(posedge clock_i);
      sda_m <= 1'b1;
      wait_n(4);
      scl_o <= 1'b1;
      wait_n(4);
      sda_m <= 1'b0;
      wait_n(4);
      scl_o <= 1'b0;
   endtask : start_cond

   // clock then stands high until the next frame
   task automatic stop_cond();
      @(posedge clock_i);
      sda_m <= 1'b0;
      wait_n(4);
      scl_o <= 1'b1;
      wait_n(4);
      sda_m <= 1'b1;
      wait_n(4);
   endtask : stop_cond

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
      bit_xfer(1'b1, r);
      ack = ~r;
   endtask : wr_byte

   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
      bit_xfer(last, r);
   endtask : rd_byte
endmodule : ioexp_master_model

// ==== tb.sv ====
// self-checking testbench of the io expander register block
`timescale 1ns/1ps

module tb;
   import ioexp_pkg::*;
   logic       clock_i  = 1'b0;
   logic       resetn_i = 1'b0;
   logic [2:0] sel      = 3'h5;
   logic [7:0] pins0    = 8'h00;
   logic [7:0] pins1    = 8'h00;
   logic       scl, sda, sda_o, sda_oe_n, irq_o, irq_oe_n;
   logic [7:0] drv0, drv1, oe0, oe1, q0, q1;
   int         fail_count = 0;
   int         n_tests    = 0;

   always #10 clock_i = ~clock_i;

   // a longer line filter would let the slave's own reply reach it after scl rises
   ioexp_regs #(
      .FILT_LEN(1)
   ) dut (
      .clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
      .addr_select_hi_i(sel[2]), .addr_select_mid_i(sel[1]), .addr_select_lo_i(sel[0]),
      .first_port_pins_i(pins0), .first_port_pins_o(drv0), .first_port_oe_n_o(oe0),
      .second_port_pins_i(pins1), .second_port_pins_o(drv1), .second_port_oe_n_o(oe1),
      .irq_o(irq_o), .irq_oe_n_o(irq_oe_n));

   ioexp_master_model u_mst (
      .clock_i(clock_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
      .scl_o(scl), .sda_line_o(sda));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run

   task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1,
                     input logic [7:0] d2, input int n);
      logic a;
      u_mst.start_cond();
      u_mst.wr_byte({DEV_ADDR_FIXED, sel, 1'b0}, a);
      check("addr ack", {7'h00, a}, 8'h01);
      u_mst.wr_byte(cmd, a);
      check("cmd ack", {7'h00, a}, 8'h01);
      if (n > 0) u_mst.wr_byte(d0, a);
      if (n > 1) u_mst.wr_byte(d1, a);
      if (n > 2) u_mst.wr_byte(d2, a);
      u_mst.stop_cond();
   endtask : wr

   // without a command the read begins with a fresh start, or a restart mid-frame
   task automatic rd(input logic use_cmd, input logic [7:0] cmd, input int n,
                     output logic [7:0] r0, output logic [7:0] r1);
      logic a;
      if (use_cmd) begin
         u_mst.start_cond();
         u_mst.wr_byte({DEV_ADDR_FIXED, sel, 1'b0}, a);
         u_mst.wr_byte(cmd, a);
      end
      u_mst.start_cond();
      u_mst.wr_byte({DEV_ADDR_FIXED, sel, 1'b1}, a);
      check("read addr ack", {7'h00, a}, 8'h01);
      u_mst.rd_byte(n == 1, r0);
      if (n > 1) u_mst.rd_byte(1'b1, r1);
      u_mst.stop_cond();
   endtask : rd

   task automatic refuse(input logic [7:0] addr);
      logic a;
      u_mst.start_cond();
      u_mst.wr_byte(addr, a);
      check("foreign addr nack", {7'h00, a}, 8'h00);
      u_mst.stop_cond();
   endtask : refuse

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clock_i);
      fail_count++;
      complete_run();
   end

   initial begin
      repeat (4) @(posedge clock_i);
      resetn_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      check("drive0 reset", drv0, DRIVE_RST);
      check("dir1 reset", oe1, DIR_RST);
      check("sda drive value", {7'h00, sda_o}, 8'h00);
      check("irq drive value", {7'h00, irq_o}, 8'h00);
      rd(1'b1, 8'h04, 2, q0, q1);
      check("inv0 reset", q0, 8'h00);
      check("inv1 reset", q1, 8'h00);
      rd(1'b1, 8'h02, 2, q0, q1);
      check("drive pair reset", q0 & q1, 8'hFF);
      rd(1'b1, 8'h06, 2, q0, q1);
      check("dir pair reset", q0 & q1, 8'hFF);
      wr(8'h03, 8'h55, 8'hAA, 8'h3C, 3);
      check("drive1 pins", drv1, 8'h3C);
      check("drive0 pins", drv0, 8'hAA);
      // pins still inputs, so a read must show the flops, not the pins
      rd(1'b1, 8'h03, 2, q0, q1);
      check("drive1 read", q0, 8'h3C);
      check("drive0 read", q1, 8'hAA);
      wr(8'h06, 8'h0F, 8'hF0, 8'h00, 2);
      check("dir0 enables", oe0, 8'h0F);
      check("dir1 enables", oe1, 8'hF0);
      pins0 <= 8'hA5;
      pins1 <= 8'h5A;
      wr(8'h04, 8'hFF, 8'h00, 8'h00, 2);
      wr(8'h00, 8'h00, 8'hFF, 8'h00, 2);
      rd(1'b1, 8'h00, 2, q0, q1);
      check("level0 inverted", q0, 8'h5A);
      check("level1 plain", q1, 8'h5A);
      rd(1'b1, 8'h04, 2, q0, q1);
      check("inv0 kept", q0, 8'hFF);
      check("inv1 kept", q1, 8'h00);
      rd(1'b0, 8'h00, 1, q0, q1);
      check("stored pointer", q0, 8'hFF);
      // a restart after one byte of register 4 must move the stored pointer to register 5
      u_mst.start_cond();
      u_mst.wr_byte({DEV_ADDR_FIXED, sel, 1'b1}, q1[0]);
      u_mst.rd_byte(1'b1, q0);
      check("restart first", q0, 8'hFF);
      rd(1'b0, 8'h00, 1, q0, q1);
      check("restart reg", q0, 8'h00);
      rd(1'b0, 8'h00, 1, q0, q1);
      check("restart kept", q0, 8'h00);
      check("irq idle", {7'h00, irq_oe_n}, 8'h01);
      pins0 <= 8'h25;
      repeat (8) @(posedge clock_i);
      check("irq output pin", {7'h00, irq_oe_n}, 8'h01);
      pins0 <= 8'h24;
      for (int i = 0; i < 8 && irq_oe_n !== 1'b0; i++) @(posedge clock_i);
      check("irq input pin", {7'h00, irq_oe_n}, 8'h00);
      rd(1'b1, 8'h01, 1, q0, q1);
      check("irq other port", {7'h00, irq_oe_n}, 8'h00);
      rd(1'b1, 8'h00, 1, q0, q1);
      check("level0 new", q0, 8'hDB);
      check("irq cleared", {7'h00, irq_oe_n}, 8'h01);
      for (int s = 0; s < 8; s++) begin
         sel <= s[2:0];
         wr(8'h02, 8'h00, 8'h00, 8'h00, 0);
         refuse({DEV_ADDR_FIXED, ~s[2:0], 1'b0});
      end
      refuse(8'h00);
      refuse({4'h5, sel, 1'b0});
      complete_run();
   end
endmodule : tb
